//--- can_mailbox_cfg.svh
// Notes on behaviour
// - Transmit code arms buffer, rescan even idle
// - Code zero deactivates the buffer
// - Abort code cancels armed or aborted buffer, sets done flag
// - Done flag polled; irq only when masked in
// - Abort disabled: inactive code deactivates silently
// - Write, frame start or intermission end rescans
`ifndef CAN_MAILBOX_CFG_SVH
`define CAN_MAILBOX_CFG_SVH
`define CODE_OFF 4'h0
`define CODE_INACTIVE 4'h8
`define CODE_ABORT 4'h9
`define CODE_TX 4'hC
`endif

//--- can_mailbox_pkg.sv
package can_mailbox_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_SCAN = 3'b010,
        ST_SEND = 3'b100
    } tx_state_t;
endpackage : can_mailbox_pkg

//--- can_mailbox_tx_arbitration.sv
`timescale 1ns/1ps
`include "can_mailbox_cfg.svh"
module can_mailbox_tx_arbitration #(
    parameter int NUM_BUFS = 16,
    parameter int IDX_W = 4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Software state code writes and reads
    input wire logic code_wr,
    input wire logic [IDX_W-1:0] code_idx,
    input wire logic [3:0] code_data,
    input wire logic [IDX_W-1:0] rd_idx,
    output logic [3:0] rd_code,
    // Control
    input wire logic abort_enable,
    input wire logic [NUM_BUFS-1:0] buffer_irq_mask,
    input wire logic [NUM_BUFS-1:0] flag_clear,
    // Bus side events
    input wire logic intermission_end,
    input wire logic frame_start,
    input wire logic bus_idle,
    input wire logic tx_done,
    // Transmit request
    output logic tx_start,
    output logic [IDX_W-1:0] tx_idx,
    // Status
    output logic [NUM_BUFS-1:0] buffer_done_flag,
    output logic irq
);
    logic [3:0] code [NUM_BUFS];
    logic [3:0] next_code [NUM_BUFS];
    logic [NUM_BUFS-1:0] next_flag;
    logic rescan;
    logic next_rescan;
    can_mailbox_pkg::tx_state_t state;
    can_mailbox_pkg::tx_state_t next_state;
    logic [IDX_W-1:0] scan;
    logic [IDX_W-1:0] next_scan;
    logic [IDX_W-1:0] next_tx_idx;
    logic found;
    logic next_found;
    logic [IDX_W-1:0] win;
    logic [IDX_W-1:0] next_win;
    logic next_tx_start;
    logic [3:0] next_rd_code;

    wire logic wr_active = code_wr && code[code_idx] == `CODE_TX;

    always_comb
    begin
        for (int i = 0; i < NUM_BUFS; i++)
        begin
            next_code[i] = code[i];
            // Hardware set wins over software clear
            next_flag[i] = buffer_done_flag[i] & ~flag_clear[i];
        end
        if (tx_done && state == can_mailbox_pkg::ST_SEND)
        begin
            next_code[tx_idx] = `CODE_INACTIVE;
            next_flag[tx_idx] = 1'b1;
        end
        if (code_wr)
        begin
            if (code_data == `CODE_ABORT && abort_enable)
            begin
                if (wr_active || code[code_idx] == `CODE_ABORT)
                begin
                    next_code[code_idx] = `CODE_ABORT;
                    next_flag[code_idx] = 1'b1;
                end
                else
                begin
                    next_code[code_idx] = `CODE_INACTIVE;
                end
            end
            else if (code_data == `CODE_ABORT)
            begin
                next_code[code_idx] = `CODE_INACTIVE;
            end
            else
            begin
                next_code[code_idx] = code_data;
            end
        end
    end

    // rescan on any code write, frame start or intermission end
    always_comb
    begin
        next_rescan = rescan;
        if (code_wr || frame_start || intermission_end)
        begin
            next_rescan = 1'b1;
        end
        else if (state == can_mailbox_pkg::ST_IDLE && bus_idle)
        begin
            next_rescan = 1'b0;
        end
    end

    // Arbitration scan: lowest index wins, no identifier compare here
    always_comb
    begin
        next_state = state;
        next_scan = scan;
        next_found = found;
        next_win = win;
        next_tx_start = 1'b0;
        next_tx_idx = tx_idx;
        case (state)
            can_mailbox_pkg::ST_IDLE:
            begin
                if ((rescan || code_wr) && bus_idle)
                begin
                    next_state = can_mailbox_pkg::ST_SCAN;
                    next_scan = '0;
                    next_found = 1'b0;
                end
            end
            can_mailbox_pkg::ST_SCAN:
            begin
                // use next_code so a same-cycle write is seen
                if (!found && next_code[scan] == `CODE_TX)
                begin
                    next_found = 1'b1;
                    next_win = scan;
                end
                if (scan == IDX_W'(NUM_BUFS - 1))
                begin
                    if (found || next_code[scan] == `CODE_TX)
                    begin
                        next_state = can_mailbox_pkg::ST_SEND;
                        next_tx_start = 1'b1;
                        next_tx_idx = found ? win : scan;
                    end
                    else
                    begin
                        next_state = can_mailbox_pkg::ST_IDLE;
                    end
                end
                else
                begin
                    next_scan = scan + 1'b1;
                end
            end
            can_mailbox_pkg::ST_SEND:
            begin
                // Aborted or deactivated mid-frame ends the wait too
                if (tx_done || code[tx_idx] != `CODE_TX)
                begin
                    next_state = can_mailbox_pkg::ST_IDLE;
                end
            end
            default:
            begin
                next_state = can_mailbox_pkg::ST_IDLE;
            end
        endcase
        next_rd_code = next_code[rd_idx];
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            for (int i = 0; i < NUM_BUFS; i++)
            begin
                code[i] <= `CODE_OFF;
            end
            buffer_done_flag <= '0;
            rescan <= 1'b0;
            state <= can_mailbox_pkg::ST_IDLE;
            scan <= '0;
            found <= 1'b0;
            win <= '0;
            tx_start <= 1'b0;
            tx_idx <= '0;
            rd_code <= 4'h0;
        end
        else
        begin
            code <= next_code;
            buffer_done_flag <= next_flag;
            rescan <= next_rescan;
            state <= next_state;
            scan <= next_scan;
            found <= next_found;
            win <= next_win;
            tx_start <= next_tx_start;
            tx_idx <= next_tx_idx;
            rd_code <= next_rd_code;
        end
    end

    assign irq = |(buffer_done_flag & buffer_irq_mask);

    a_abort_flag: assert property (
        @(posedge clk) disable iff (!arst_n)
        code_wr && abort_enable && code_data == `CODE_ABORT && wr_active
        |=> buffer_done_flag[$past(code_idx)])
        else $error("abort did not set done flag");

    a_zero_off: assert property (
        @(posedge clk) disable iff (!arst_n)
        code_wr && code_data == `CODE_OFF |=> code[$past(code_idx)] == 4'h0)
        else $error("zero code did not deactivate");

    a_silent_off: assert property (
        @(posedge clk) disable iff (!arst_n)
        code_wr && !abort_enable && code_data == `CODE_ABORT
        |=> code[$past(code_idx)] == `CODE_INACTIVE)
        else $error("inactive write wrong");

    a_irq_mask: assert property (
        @(posedge clk) disable iff (!arst_n)
        tx_done && state == can_mailbox_pkg::ST_SEND
        && buffer_irq_mask[tx_idx]
        |=> irq || buffer_irq_mask != $past(buffer_irq_mask))
        else $error("masked done flag raised no irq");

    a_arm_scan: assert property (
        @(posedge clk) disable iff (!arst_n)
        code_wr && code_data == `CODE_TX && bus_idle
        && state == can_mailbox_pkg::ST_IDLE
        |=> state == can_mailbox_pkg::ST_SCAN)
        else $error("armed buffer not scanned");

    a_late_write: assert property (
        @(posedge clk) disable iff (!arst_n)
        state == can_mailbox_pkg::ST_SCAN && scan == IDX_W'(NUM_BUFS - 1)
        && code_wr && code_idx == scan && code_data == `CODE_TX
        |=> tx_start)
        else $error("late write missed by scan");

    a_rescan_evt: assert property (
        @(posedge clk) disable iff (!arst_n)
        (frame_start || intermission_end) |=> rescan)
        else $error("rescan not requested");

    a_flag_sticky: assert property (
        @(posedge clk) disable iff (!arst_n)
        buffer_done_flag[5] && !flag_clear[5] |=> buffer_done_flag[5])
        else $error("done flag lost");
endmodule : can_mailbox_tx_arbitration

//--- can_bus_node_model.sv
`timescale 1ns/1ps
module can_bus_node_model #(
    parameter int FRAME = 6
) (
    // Clock, transmit request and frame length select
    input wire logic clk,
    input wire logic tx_start,
    input wire logic slow,
    // Bus events
    output logic bus_idle,
    output logic tx_done,
    output logic intermission_end
);
    initial
    begin
        bus_idle = 1'b1;
        tx_done = 1'b0;
        intermission_end = 1'b0;
        forever
        begin
            @(negedge clk);
            if (tx_start === 1'b1)
            begin
                // Non-blocking so bench reads at this edge stay race free
                bus_idle <= 1'b0;
                repeat (slow ? 8 * FRAME : FRAME) @(negedge clk);
                tx_done <= 1'b1;
                @(negedge clk);
                tx_done <= 1'b0;
                intermission_end <= 1'b1;
                @(negedge clk);
                intermission_end <= 1'b0;
                bus_idle <= 1'b1;
            end
        end
    end
endmodule : can_bus_node_model

//--- can_mailbox_tx_arbitration_tb.sv
`timescale 1ns/1ps
`include "can_mailbox_cfg.svh"
module can_mailbox_tx_arbitration_tb;
    logic clk;
    logic arst_n;
    logic code_wr;
    logic [3:0] code_idx;
    logic [3:0] code_data;
    logic [3:0] rd_idx;
    logic [3:0] rd_code;
    logic abort_enable;
    logic [15:0] buffer_irq_mask;
    logic [15:0] flag_clear;
    logic intermission_end;
    logic frame_start;
    logic bus_idle;
    logic tx_done;
    logic tx_start;
    logic [3:0] tx_idx;
    logic [15:0] buffer_done_flag;
    logic irq;
    logic slow;
    int failures;
    int cmp_count;
    int n;
    int txc;

    can_mailbox_tx_arbitration i_dut (.clk(clk), .arst_n(arst_n),
        .code_wr(code_wr), .code_idx(code_idx), .code_data(code_data),
        .rd_idx(rd_idx), .rd_code(rd_code), .abort_enable(abort_enable),
        .buffer_irq_mask(buffer_irq_mask), .flag_clear(flag_clear),
        .intermission_end(intermission_end), .frame_start(frame_start),
        .bus_idle(bus_idle), .tx_done(tx_done), .tx_start(tx_start),
        .tx_idx(tx_idx), .buffer_done_flag(buffer_done_flag), .irq(irq));
    can_bus_node_model i_bus (.clk(clk), .tx_start(tx_start), .slow(slow),
        .bus_idle(bus_idle), .tx_done(tx_done),
        .intermission_end(intermission_end));

    initial
    begin
        clk = 1'b0;
        forever
            #20 clk = ~clk;
    end

    always @(posedge clk)
        if (tx_start === 1'b1)
            txc++;

    task automatic chk(input string what, input logic [15:0] seen,
        input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [3:0] idx, input logic [3:0] data);
        code_idx = idx;
        code_data = data;
        code_wr = 1'b1;
        @(negedge clk);
        code_wr = 1'b0;
        // Idle edge keeps back to back writes apart
        @(negedge clk);
    endtask : wr

    task automatic rd(input logic [3:0] idx, input logic [3:0] exp);
        rd_idx = idx;
        repeat (2) @(negedge clk);
        chk("rd_code", {12'h000, rd_code}, {12'h000, exp});
    endtask : rd

    task automatic clr(input logic [15:0] mask);
        flag_clear = mask;
        @(negedge clk);
        flag_clear = 16'h0000;
        @(negedge clk);
    endtask : clr

    // Waits for a start, then for the frame to finish on the bus
    task automatic wait_tx(input logic [3:0] idx, input int lat);
        n = 0;
        while (tx_start !== 1'b1 && n < 300)
        begin
            @(negedge clk);
            n++;
        end
        chk("tx_start", {15'h0000, tx_start}, 16'h0001);
        chk("tx_idx", {12'h000, tx_idx}, {12'h000, idx});
        if (lat > 0)
            chk("latency", n[15:0], lat[15:0]);
        @(negedge clk);
        while (bus_idle !== 1'b1 && n < 300)
        begin
            @(negedge clk);
            n++;
        end
        if (n >= 300)
            failures++;
        repeat (2) @(negedge clk);
    endtask : wait_tx

    task automatic finish_test;
        $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : finish_test

    initial
    begin
        #(40 * 5000);
        failures++;
        finish_test();
    end

    initial
    begin
        failures = 0;
        cmp_count = 0;
        txc = 0;
        arst_n = 1'b0;
        code_wr = 1'b0;
        code_idx = 4'h0;
        code_data = 4'h0;
        rd_idx = 4'h0;
        abort_enable = 1'b1;
        buffer_irq_mask = 16'h0020;
        flag_clear = 16'h0000;
        frame_start = 1'b0;
        slow = 1'b0;
        repeat (8) @(negedge clk);
        arst_n = 1'b1;
        rd(4'h5, `CODE_OFF);
        wr(4'h0, `CODE_INACTIVE);
        wr(4'h0, `CODE_INACTIVE);
        // Let the scans started by those writes run out
        repeat (40) @(negedge clk);
        wr(4'h5, `CODE_TX);
        wait_tx(4'h5, 15);
        rd(4'h5, `CODE_INACTIVE);
        chk("flags", buffer_done_flag, 16'h0020);
        chk("irq", {15'h0000, irq}, 16'h0001);
        buffer_irq_mask = 16'h0000;
        @(negedge clk);
        chk("irq", {15'h0000, irq}, 16'h0000);
        clr(16'h0020);
        chk("flags", buffer_done_flag, 16'h0000);
        // Post-frame rescan must be over before timed arming
        repeat (20) @(negedge clk);
        // Slow far side, arming two cycles apart
        slow = 1'b1;
        wr(4'h7, `CODE_TX);
        wr(4'h3, `CODE_TX);
        wait_tx(4'h3, 13);
        wait_tx(4'h7, 0);
        slow = 1'b0;
        repeat (20) @(negedge clk);
        // Arm lands one clock before its scan slot
        wr(4'h2, `CODE_TX);
        repeat (10) @(negedge clk);
        wr(4'hC, `CODE_TX);
        wait_tx(4'h2, 0);
        wait_tx(4'hC, 0);
        repeat (20) @(negedge clk);
        // Frame start rescans; arm lands on the last slot
        txc = 0;
        frame_start = 1'b1;
        @(negedge clk);
        frame_start = 1'b0;
        repeat (16) @(negedge clk);
        wr(4'hF, `CODE_TX);
        chk("tx_count", txc[15:0], 16'h0001);
        chk("tx_idx", {12'h000, tx_idx}, 16'h000F);
        repeat (40) @(negedge clk);
        chk("flags", buffer_done_flag, 16'h908C);
        clr(16'hFFFF);
        txc = 0;
        wr(4'h9, `CODE_TX);
        wr(4'h9, `CODE_ABORT);
        abort_enable = 1'b0;
        wr(4'hA, `CODE_TX);
        wr(4'hA, `CODE_INACTIVE);
        wr(4'hB, `CODE_TX);
        wr(4'hB, `CODE_OFF);
        wr(4'hD, `CODE_TX);
        wr(4'hD, `CODE_ABORT);
        repeat (40) @(negedge clk);
        rd(4'h9, `CODE_ABORT);
        rd(4'hA, `CODE_INACTIVE);
        rd(4'hB, `CODE_OFF);
        rd(4'hD, `CODE_INACTIVE);
        rd(4'h0, `CODE_INACTIVE);
        chk("flags", buffer_done_flag, 16'h0200);
        chk("tx_count", txc[15:0], 16'h0000);
        finish_test();
    end
endmodule : can_mailbox_tx_arbitration_tb
